// ===== logic/lsm_regs.sv
// Register bank for status pin, tuning, powerdown and lock status.
//
// Function
// - Bits 7:3 of the pin config select the status pin source, reset 2.
// - Codes 8 to 10 route DAC flags and 11 to 18 route divider outputs.
// - Bits 2:0 pick push-pull 3, inverted 4 or open drain 6 (reset).
// - Powerdown bit 6 stops the loop2 prescaler and bit 5 stops loop2.
// - The lock-lost flag sets on a falling loop1 lock edge and sticks.
// - Releasing clear while lock is low does not set the flag.
// - Bit 1 of lock status reads the loop1 lock level registered one clock earlier.
// - Clear bit 0 at one holds the flag at zero until software drops it.
`timescale 1ns/1ps
module lsm_regs (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [13:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [13:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        loop1_dld,
   input  wire logic        loop2_dld,
   input  wire logic        holdover,
   input  wire logic        dac_locked,
   input  wire logic        spi_readback,
   input  wire logic        dac_rail,
   input  wire logic        dac_low,
   input  wire logic        dac_high,
   input  wire logic [7:0]  div_outs,
   output logic             status_pin_b_o,
   output logic             status_pin_b_oe_n,
   output logic             loop2_prescaler_powerdown,
   output logic             loop2_powerdown,
   output logic [7:0]       fixed_tuning_a,
   output logic [7:0]       fixed_tuning_b,
   output logic [7:0]       vco_temp_opt_a,
   output logic [7:0]       vco_temp_opt_b
);
   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [7:0]  fixa_q, fixa_d;
   logic [7:0]  fixb_q, fixb_d;
   logic [7:0]  pwr_q, pwr_d;
   logic [7:0]  opta_q, opta_d;
   logic [7:0]  optb_q, optb_d;
   logic [4:0]  sel_q, sel_d;
   logic [2:0]  drv_q, drv_d;
   logic        clr_q, clr_d;

   // ****************************************************************
   // Bus state
   // ****************************************************************
   logic        aw_hold_q, aw_hold_d;
   logic        w_hold_q, w_hold_d;
   logic [13:0] awaddr_q, awaddr_d;
   logic [7:0]  wdata_q, wdata_d;
   logic        wstrb_q, wstrb_d;
   logic        bvalid_q, bvalid_d;
   logic [1:0]  bresp_q, bresp_d;
   logic        rvalid_q, rvalid_d;
   logic [1:0]  rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic        do_write;
   logic        hit;
   logic        lost;
   logic        lock_level;
   logic [7:0]  rd_byte;
   logic        rd_hit;

   assign s_axi_awready = !aw_hold_q && !bvalid_q;
   assign s_axi_wready  = !w_hold_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign do_write      = aw_hold_q && w_hold_q && !bvalid_q;

   always_comb begin
      aw_hold_d = aw_hold_q;
      w_hold_d  = w_hold_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_d = 1'b1;
         awaddr_d  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_hold_d = 1'b1;
         wdata_d  = s_axi_wdata[7:0];
         wstrb_d  = s_axi_wstrb[0];
      end
      if (do_write) begin
         aw_hold_d = 1'b0;
         w_hold_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = hit ? lsm_pkg::RESP_OKAY : lsm_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   // ****************************************************************
   // Register writes
   // ****************************************************************
   always_comb begin
      fixa_d = fixa_q;
      fixb_d = fixb_q;
      pwr_d  = pwr_q;
      opta_d = opta_q;
      optb_d = optb_q;
      sel_d  = sel_q;
      drv_d  = drv_q;
      clr_d  = clr_q;
      hit    = 1'b1;
      unique case ({awaddr_q[13:2], 2'b00})
         lsm_pkg::ADDR_FIXED_A: if (do_write && wstrb_q) fixa_d = wdata_q;
         lsm_pkg::ADDR_FIXED_B: if (do_write && wstrb_q) fixb_d = wdata_q;
         lsm_pkg::ADDR_PWRDN: if (do_write && wstrb_q) begin
            pwr_d = wdata_q & lsm_pkg::MASK_PWRDN;
         end
         lsm_pkg::ADDR_OPT_A: if (do_write && wstrb_q) opta_d = wdata_q;
         lsm_pkg::ADDR_OPT_B: if (do_write && wstrb_q) optb_d = wdata_q;
         lsm_pkg::ADDR_LOCK_STAT: if (do_write && wstrb_q) begin
            clr_d = wdata_q[lsm_pkg::POS_CLEAR];
         end
         lsm_pkg::ADDR_PIN_B_CFG: if (do_write && wstrb_q) begin
            sel_d = wdata_q[7:3];
            drv_d = wdata_q[2:0];
         end
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fixa_q    <= lsm_pkg::RST_FIXED_A;
         fixb_q    <= lsm_pkg::RST_FIXED_B;
         pwr_q     <= lsm_pkg::RST_PWRDN;
         opta_q    <= lsm_pkg::RST_OPT;
         optb_q    <= lsm_pkg::RST_OPT;
         sel_q     <= lsm_pkg::RST_SRC_SEL;
         drv_q     <= lsm_pkg::RST_DRV_TYPE;
         clr_q     <= 1'b0;
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= 14'h0000;
         wdata_q   <= 8'h00;
         wstrb_q   <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= 2'b00;
      end else begin
         fixa_q    <= fixa_d;
         fixb_q    <= fixb_d;
         pwr_q     <= pwr_d;
         opta_q    <= opta_d;
         optb_q    <= optb_d;
         sel_q     <= sel_d;
         drv_q     <= drv_d;
         clr_q     <= clr_d;
         aw_hold_q <= aw_hold_d;
         w_hold_q  <= w_hold_d;
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   always_comb begin
      rd_byte = 8'h00;
      rd_hit  = 1'b1;
      unique case ({s_axi_araddr[13:2], 2'b00})
         lsm_pkg::ADDR_FIXED_A:   rd_byte = fixa_q;
         lsm_pkg::ADDR_FIXED_B:   rd_byte = fixb_q;
         lsm_pkg::ADDR_PWRDN:     rd_byte = pwr_q;
         lsm_pkg::ADDR_OPT_A:     rd_byte = opta_q;
         lsm_pkg::ADDR_OPT_B:     rd_byte = optb_q;
         lsm_pkg::ADDR_LOCK_STAT: rd_byte = {5'h00, lost, lock_level, clr_q};
         lsm_pkg::ADDR_PIN_B_CFG: rd_byte = {sel_q, drv_q};
         default:                 rd_hit  = 1'b0;
      endcase
   end

   always_comb begin
      rvalid_d = rvalid_q;
      rresp_d  = rresp_q;
      rdata_d  = rdata_q;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rdata_d  = {24'h000000, rd_byte};
         rresp_d  = rd_hit ? lsm_pkg::RESP_OKAY : lsm_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q  <= 2'b00;
         rdata_q  <= 32'h00000000;
      end else begin
         rvalid_q <= rvalid_d;
         rresp_q  <= rresp_d;
         rdata_q  <= rdata_d;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp  = rresp_q;
   assign s_axi_rdata  = rdata_q;

   // ****************************************************************
   // Outputs and submodules
   // ****************************************************************
   assign loop2_prescaler_powerdown = pwr_q[lsm_pkg::POS_PRE_PD];
   assign loop2_powerdown           = pwr_q[lsm_pkg::POS_LOOP2_PD];
   assign fixed_tuning_a            = fixa_q;
   assign fixed_tuning_b            = fixb_q;
   assign vco_temp_opt_a            = opta_q;
   assign vco_temp_opt_b            = optb_q;

   lsm_lost_flag u_lost (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .lock_in    (loop1_dld),
      .hold_clear (clr_q),
      .lost       (lost),
      .lock_level (lock_level)
   );

   lsm_pin_driver u_pin (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .source_sel   (sel_q),
      .drive_type   (drv_q),
      .loop1_lock   (loop1_dld),
      .loop2_lock   (loop2_dld),
      .holdover     (holdover),
      .dac_locked   (dac_locked),
      .spi_readback (spi_readback),
      .dac_flags    ({dac_high, dac_low, dac_rail}),
      .div_outs     (div_outs),
      .pin_o        (status_pin_b_o),
      .pin_oe_n     (status_pin_b_oe_n)
   );
endmodule

// ===== inc/lsm_pkg.sv
// Package of register map, field layout and reset values for the block.
package lsm_pkg;
   // ****************************************************************
   // Register byte offsets (index times four)
   // ****************************************************************
   localparam logic [11:0] IDX_FIXED_A    = 12'h171;
   localparam logic [11:0] IDX_FIXED_B    = 12'h172;
   localparam logic [11:0] IDX_PWRDN      = 12'h173;
   localparam logic [11:0] IDX_OPT_A      = 12'h17c;
   localparam logic [11:0] IDX_OPT_B      = 12'h17d;
   localparam logic [11:0] IDX_LOCK_STAT  = 12'h182;
   localparam logic [11:0] IDX_PIN_B_CFG  = 12'h170;
   localparam logic [13:0] ADDR_FIXED_A   = {IDX_FIXED_A, 2'b00};
   localparam logic [13:0] ADDR_FIXED_B   = {IDX_FIXED_B, 2'b00};
   localparam logic [13:0] ADDR_PWRDN     = {IDX_PWRDN, 2'b00};
   localparam logic [13:0] ADDR_OPT_A     = {IDX_OPT_A, 2'b00};
   localparam logic [13:0] ADDR_OPT_B     = {IDX_OPT_B, 2'b00};
   localparam logic [13:0] ADDR_LOCK_STAT = {IDX_LOCK_STAT, 2'b00};
   localparam logic [13:0] ADDR_PIN_B_CFG = {IDX_PIN_B_CFG, 2'b00};

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] RST_FIXED_A   = 8'h0a;
   localparam logic [7:0] RST_FIXED_B   = 8'h00;
   localparam logic [7:0] RST_PWRDN     = 8'h00;
   localparam logic [7:0] RST_OPT       = 8'h00;
   localparam logic [4:0] RST_SRC_SEL   = 5'h02;
   localparam logic [2:0] RST_DRV_TYPE  = 3'h6;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int POS_PRE_PD   = 6;
   localparam int POS_LOOP2_PD = 5;
   localparam int POS_LOST     = 2;
   localparam int POS_LOCK_RB  = 1;
   localparam int POS_CLEAR    = 0;
   localparam logic [7:0] MASK_PWRDN = 8'h60;

   // ****************************************************************
   // Source select codes and drive types
   // ****************************************************************
   localparam logic [4:0] SRC_LOW      = 5'h00;
   localparam logic [4:0] SRC_L1_LOCK  = 5'h01;
   localparam logic [4:0] SRC_L2_LOCK  = 5'h02;
   localparam logic [4:0] SRC_BOTH     = 5'h03;
   localparam logic [4:0] SRC_HOLD     = 5'h04;
   localparam logic [4:0] SRC_DAC_LOCK = 5'h05;
   localparam logic [4:0] SRC_READBACK = 5'h07;
   localparam logic [4:0] SRC_DAC_RAIL = 5'h08;
   localparam logic [4:0] SRC_DAC_LOW  = 5'h09;
   localparam logic [4:0] SRC_DAC_HIGH = 5'h0a;
   localparam logic [4:0] SRC_DIV_LO   = 5'h0b;
   localparam logic [4:0] SRC_DIV_HI   = 5'h12;
   localparam logic [2:0] DRV_PUSH     = 3'h3;
   localparam logic [2:0] DRV_PUSH_INV = 3'h4;
   localparam logic [2:0] DRV_OPEN     = 3'h6;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== logic/lsm_pin_driver.sv
// Status pin source multiplexer and output driver.
`timescale 1ns/1ps
module lsm_pin_driver (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [4:0] source_sel,
   input  wire logic [2:0] drive_type,
   input  wire logic       loop1_lock,
   input  wire logic       loop2_lock,
   input  wire logic       holdover,
   input  wire logic       dac_locked,
   input  wire logic       spi_readback,
   input  wire logic [2:0] dac_flags,
   input  wire logic [7:0] div_outs,
   output logic            pin_o,
   output logic            pin_oe_n
);
   logic       src;
   logic       pin_d;
   logic       pin_q;
   logic       oe_n_d;
   logic       oe_n_q;
   logic [4:0] div_idx;

   assign div_idx = source_sel - lsm_pkg::SRC_DIV_LO;

   always_comb begin
      src = 1'b0;
      if (source_sel == lsm_pkg::SRC_L1_LOCK) begin
         src = loop1_lock;
      end else if (source_sel == lsm_pkg::SRC_L2_LOCK) begin
         src = loop2_lock;
      end else if (source_sel == lsm_pkg::SRC_BOTH) begin
         src = loop1_lock & loop2_lock;
      end else if (source_sel == lsm_pkg::SRC_HOLD) begin
         src = holdover;
      end else if (source_sel == lsm_pkg::SRC_DAC_LOCK) begin
         src = dac_locked;
      end else if (source_sel == lsm_pkg::SRC_READBACK) begin
         src = spi_readback;
      end else if (source_sel >= lsm_pkg::SRC_DAC_RAIL &&
                   source_sel <= lsm_pkg::SRC_DAC_HIGH) begin
         src = dac_flags[source_sel[1:0]];
      end else if (source_sel >= lsm_pkg::SRC_DIV_LO &&
                   source_sel <= lsm_pkg::SRC_DIV_HI) begin
         src = div_outs[div_idx[2:0]];
      end
   end

   always_comb begin
      pin_d  = 1'b0;
      oe_n_d = 1'b1;
      if (drive_type == lsm_pkg::DRV_PUSH) begin
         pin_d  = src;
         oe_n_d = 1'b0;
      end else if (drive_type == lsm_pkg::DRV_PUSH_INV) begin
         pin_d  = ~src;
         oe_n_d = 1'b0;
      end else if (drive_type == lsm_pkg::DRV_OPEN) begin
         // Open drain only pulls low; high is left to the pull-up.
         pin_d  = 1'b0;
         oe_n_d = src;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_q  <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         pin_q  <= pin_d;
         oe_n_q <= oe_n_d;
      end
   end

   assign pin_o    = pin_q;
   assign pin_oe_n = oe_n_q;
endmodule

// ===== logic/lsm_lost_flag.sv
// Sticky lock-lost flag with edge detection and hold-clear control.
`timescale 1ns/1ps
module lsm_lost_flag (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic lock_in,
   input  wire logic hold_clear,
   output logic      lost,
   output logic      lock_level
);
   logic lock_d;
   logic lock_q;
   logic lost_d;
   logic lost_q;

   always_comb begin
      lock_d = lock_in;
      lost_d = lost_q;
      if (lock_q && !lock_in) begin
         lost_d = 1'b1;
      end
      // Clear control holds it at zero.
      if (hold_clear) begin
         lost_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_q <= 1'b0;
         lost_q <= 1'b0;
      end else begin
         lock_q <= lock_d;
         lost_q <= lost_d;
      end
   end

   // Only an edge sets it, never a low level at release.
   assign lost       = lost_q;
   assign lock_level = lock_q;
endmodule

// ===== tb/lsm_regs_sva.sv
// Checker of bus handshakes and output relations of the register bank.
`timescale 1ns/1ps
module lsm_regs_sva (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        status_pin_b_o,
   input wire logic        status_pin_b_oe_n,
   input wire logic        loop2_prescaler_powerdown,
   input wire logic        loop2_powerdown,
   input wire logic [7:0]  fixed_tuning_a,
   input wire logic [7:0]  fixed_tuning_b,
   input wire logic [7:0]  vco_temp_opt_a,
   input wire logic [7:0]  vco_temp_opt_b
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ******
   // Bus handshakes
   // ******
   chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response left before it was taken");
   chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer changed before it was taken");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read answer missing one cycle after request");
   // Both channels are held for one cycle before the register is written.
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response missing two cycles after request");
   chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   chk_aw_refused: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");

   // ******
   // Register outputs
   // ******
   chk_rdata_upper: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   // A register may only move at the edge that raises the write response.
   chk_pd_write: assert property (
      $changed({loop2_prescaler_powerdown, loop2_powerdown})
      |-> $rose(s_axi_bvalid))
      else $error("powerdown moved without a write");
   chk_tune_write: assert property (
      $changed({fixed_tuning_a, fixed_tuning_b, vco_temp_opt_a,
      vco_temp_opt_b}) |-> $rose(s_axi_bvalid))
      else $error("tuning register moved without a write");
   // No drive type may drive the pin high while the driver is released.
   chk_pin_drive: assert property (
      status_pin_b_o |-> !status_pin_b_oe_n)
      else $error("pin high while driver released");

   cov_write: cover property (s_axi_bvalid && s_axi_bready);
   cov_read_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   cov_pin_high: cover property (status_pin_b_o);
endmodule

// ===== tb/lock_status_misc_regs_test.sv
// Self-checking bench of the lock status and misc register bank.
`timescale 1ns/1ps
module lock_status_misc_regs_test;
   localparam logic [13:0] A_PIN = lsm_pkg::ADDR_PIN_B_CFG;
   localparam logic [13:0] A_LK  = lsm_pkg::ADDR_LOCK_STAT;
   localparam logic [13:0] A_FA  = lsm_pkg::ADDR_FIXED_A;
   localparam logic [13:0] A_BAD = 14'h05a0;
   localparam logic [1:0]  OK    = lsm_pkg::RESP_OKAY;
   localparam logic [1:0]  ERR   = lsm_pkg::RESP_SLVERR;
   localparam int          LIMIT = 12000;

   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [13:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0]  wstrb = '0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        pin_o, pin_oe_n, pre_pd, l2_pd;
   logic [1:0]  bresp, rresp;
   logic [7:0]  fa, fb, oa, ob;
   // Bit 0 loop1 lock, 1 loop2 lock, 2..7 status flags, 15:8 dividers.
   logic [15:0] in_v = 16'h0002;
   logic [33:0] rq [$];
   logic [1:0]  bq [$];
   int          failures = 0, samples_checked = 0, cycles = 0;
   logic [13:0] ra [7] = '{A_PIN, A_FA, lsm_pkg::ADDR_FIXED_B,
      lsm_pkg::ADDR_PWRDN, lsm_pkg::ADDR_OPT_A, lsm_pkg::ADDR_OPT_B, A_LK};
   logic [7:0]  rv [7] = '{8'h16, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0]  rm [6] = '{8'hff, 8'hff, 8'hff, 8'h60, 8'hff, 8'hff};

   initial forever #20 aclk = ~aclk;

   lsm_regs lsm_regs_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .loop1_dld(in_v[0]), .loop2_dld(in_v[1]),
      .holdover(in_v[2]), .dac_locked(in_v[3]), .spi_readback(in_v[4]),
      .dac_rail(in_v[5]), .dac_low(in_v[6]), .dac_high(in_v[7]),
      .div_outs(in_v[15:8]), .status_pin_b_o(pin_o),
      .status_pin_b_oe_n(pin_oe_n), .loop2_prescaler_powerdown(pre_pd),
      .loop2_powerdown(l2_pd), .fixed_tuning_a(fa), .fixed_tuning_b(fb),
      .vco_temp_opt_a(oa), .vco_temp_opt_b(ob));

   task automatic final_report();
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [13:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] r);
      bit ad = 0;
      bit wd = 0;
      bq.push_back(r);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            ad = 1;
            awvalid <= 1'h0;
         end
         if (wvalid && wready) begin
            wd = 1;
            wvalid <= 1'h0;
         end
      end
      do @(posedge aclk); while (!bvalid);
      bready <= 1'h0;
   endtask

   task automatic rd(input logic [13:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      rq.push_back({r, d});
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'h0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'h0;
   endtask

   task automatic digital_lock_detect(input logic v);
      @(posedge aclk);
      in_v[0] <= v;
      repeat (3) @(posedge aclk);
   endtask

   function automatic logic [1:0] exp_pin(input logic [4:0] s,
      input logic [2:0] t, input logic [15:0] v);
      logic x;
      x = 1'h0;
      if (s >= 5'h07 && s <= 5'h12) x = v[s - 5'h03];
      else if (s == 5'h04 || s == 5'h05) x = v[s - 5'h02];
      else if (s == 5'h01 || s == 5'h02) x = v[s - 5'h01];
      else if (s == 5'h03) x = v[0] & v[1];
      case (t)
         3'h3: return {x, 1'h0};
         3'h4: return {~x, 1'h0};
         3'h6: return {1'h0, x};
         default: return 2'h1;
      endcase
   endfunction

   // Responses are compared in the order the driver noted them.
   always @(posedge aclk) begin
      if (aresetn && bvalid && bready)
         check({32'h0, bresp}, {32'h0, bq.pop_front()});
      if (aresetn && rvalid && rready)
         check({rresp, rdata}, rq.pop_front());
   end

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         failures++;
         final_report();
      end
   end

   initial begin
      logic [31:0] d;
      void'($urandom(81));
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      check(34'({pin_o, pin_oe_n}), 34'h1);
      for (int i = 0; i < 7; i++)
         rd(ra[i], {24'h0, rv[i]}, OK);
      for (int i = 0; i < 6; i++) begin
         d = $urandom;
         wr(ra[i], d, 4'hf, OK);
         rd(ra[i], {24'h0, d[7:0] & rm[i]}, OK);
      end
      wr(ra[3], 32'h40, 4'hf, OK);
      check(34'({pre_pd, l2_pd}), 34'h2);
      wr(ra[3], 32'h20, 4'hf, OK);
      check(34'({pre_pd, l2_pd}), 34'h1);
      wr(A_FA, 32'haa, 4'hf, OK);
      wr(ra[2], 32'h02, 4'hf, OK);
      wr(ra[4], 32'h15, 4'hf, OK);
      wr(ra[5], 32'h33, 4'hf, OK);
      wr(A_BAD, 32'h01, 4'hf, ERR);
      check(34'({fa, fb, oa, ob}), 34'haa021533);
      wr(A_FA, 32'h55, 4'he, OK);
      rd(A_FA, 32'haa, OK);
      rd(A_BAD, 32'h0, ERR);
      // pin A select lives outside, so all codes are legal here.
      for (int t = 0; t < 8; t++) begin
         for (int s = 0; s < 32; s++) begin
            @(posedge aclk);
            in_v <= 16'($urandom);
            wr(A_PIN, 32'(s * 8 + t), 4'hf, OK);
            repeat (2) @(posedge aclk);
            @(negedge aclk);
            d = 32'(exp_pin(5'(s), 3'(t), in_v));
            check(34'({pin_o, pin_oe_n}), 34'(d[1:0]));
         end
      end
      digital_lock_detect(1'h1);
      wr(A_LK, 32'h1, 4'hf, OK);
      wr(A_LK, 32'h0, 4'hf, OK);
      rd(A_LK, 32'h02, OK);
      digital_lock_detect(1'h0);
      rd(A_LK, 32'h04, OK);
      wr(A_LK, 32'hff, 4'hf, OK);
      digital_lock_detect(1'h1);
      digital_lock_detect(1'h0);
      rd(A_LK, 32'h01, OK);
      wr(A_LK, 32'h0, 4'hf, OK);
      rd(A_LK, 32'h00, OK);
      digital_lock_detect(1'h1);
      digital_lock_detect(1'h0);
      rd(A_LK, 32'h04, OK);
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      rd(A_FA, 32'h0a, OK);
      final_report();
   end
endmodule

bind lsm_regs lsm_regs_sva lsm_regs_sva_i (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .status_pin_b_o(status_pin_b_o), .status_pin_b_oe_n(status_pin_b_oe_n),
   .loop2_prescaler_powerdown(loop2_prescaler_powerdown),
   .loop2_powerdown(loop2_powerdown), .fixed_tuning_a(fixed_tuning_a),
   .fixed_tuning_b(fixed_tuning_b), .vco_temp_opt_a(vco_temp_opt_a),
   .vco_temp_opt_b(vco_temp_opt_b));
